// file: pkg/uhc_pkg.sv
// Package: register map, field layout and reset values of the host capability bank
package uhc_pkg;
  localparam int unsigned ADDR_W = 12;
  // Capability area offsets (byte addresses from block base)
  localparam logic [11:0] OFS_CAPLEN_VER = 12'h000;
  localparam logic [11:0] OFS_STRUCT     = 12'h004;
  localparam logic [11:0] OFS_CAPPAR     = 12'h008;
  localparam logic [11:0] OFS_ROUTE_LO   = 12'h00c;
  localparam logic [11:0] OFS_ROUTE_HI   = 12'h010;
  // Operational area base and command register
  localparam logic [11:0] OFS_OPER_BASE  = 12'h010;
  localparam logic [11:0] OFS_HOST_CMD   = 12'h010;
  localparam logic [7:0]  CAP_LENGTH     = 8'h10;
  // Structural parameter field positions
  localparam int unsigned SP_NPORT_LSB   = 0;
  localparam int unsigned SP_PPC_BIT     = 4;
  localparam int unsigned SP_PRR_BIT     = 7;
  localparam int unsigned SP_NPCC_LSB    = 8;
  localparam int unsigned SP_NCC_LSB     = 12;
  localparam int unsigned SP_PIND_BIT    = 16;
  localparam int unsigned SP_DPN_LSB     = 20;
  localparam logic [3:0]  NUM_PORTS      = 4'h2;
  localparam logic [3:0]  NUM_COMPANIONS = 4'h1;
  localparam logic [3:0]  PORTS_PER_CC   = 4'h2;
  localparam logic [3:0]  DEBUG_PORT     = 4'h0;
  localparam logic        ROUTE_RULE     = 1'b0;
  localparam logic        PORT_PWR_SW    = 1'b1;
  localparam logic        PORT_IND       = 1'b0;
  // Capability parameter field positions
  localparam int unsigned CP_WIDE_ADDRESS_CAPABLE_BIT    = 0;
  localparam int unsigned CP_FRAME_LIST_PROGRAMMABLE_BIT    = 1;
  localparam int unsigned CP_PARK_CAPABLE_BIT    = 2;
  localparam int unsigned CP_IST_LSB     = 4;
  localparam int unsigned CP_EXTENDED_CAP_POINTER_LSB    = 8;
  localparam logic [7:0]  EXT_CAP_PTR    = 8'ha0;
  localparam logic [3:0]  ISO_THRESH     = 4'h1;
  localparam logic        PARK_CAP       = 1'b1;
  localparam logic        FLIST_PROG     = 1'b1;
  localparam logic        WIDE_ADDR      = 1'b0;
  localparam logic [59:0] ROUTE_RESET    = 60'h0;
  // Command register fields
  localparam int unsigned CMD_RS_BIT     = 0;
  localparam int unsigned CMD_HCR_BIT    = 1;
  localparam int unsigned CMD_FLS_LSB    = 2;
  localparam int unsigned CMD_PSE_BIT    = 4;
  localparam int unsigned CMD_ASE_BIT    = 5;
  localparam int unsigned CMD_ASYNC_ADVANCE_DOORBELL_BIT   = 6;
  localparam int unsigned CMD_LIGHT_CONTROLLER_RESET_BIT   = 7;
  localparam int unsigned CMD_PMC_LSB    = 8;
  localparam int unsigned CMD_PME_BIT    = 11;
  localparam int unsigned CMD_ITC_LSB    = 16;
  localparam logic [31:0] CMD_RESET      = 32'h0008_0b00;
  localparam logic [31:0] CMD_RW_MASK    = 32'h00ff_0bff;
endpackage : uhc_pkg

// file: rtl/uhc_cap_rom.sv
// Constant capability words assembled from the package fields
`timescale 1ns/1ns
`default_nettype none
module uhc_cap_rom
  import uhc_pkg::*;
#(
  parameter logic [15:0] IFACE_VERSION = 16'h0abc, // Arbitrary value, set per product
  parameter logic [3:0]  N_PORTS       = 4'h2
) (
  output logic [31:0] cap0_o,   // Length and version word
  output logic [31:0] struct_o, // Structural parameters
  output logic [31:0] cappar_o, // Capability parameters
  output logic [63:0] route_o   // Companion route map
);
  // Field placement; all other bits are reserved and read zero
  assign cap0_o   = {IFACE_VERSION, 8'h00, CAP_LENGTH};
  assign struct_o = (32'(N_PORTS) << SP_NPORT_LSB)
                  | (32'(PORT_PWR_SW) << SP_PPC_BIT)
                  | (32'(ROUTE_RULE) << SP_PRR_BIT)
                  | (32'(PORTS_PER_CC) << SP_NPCC_LSB)
                  | (32'(NUM_COMPANIONS) << SP_NCC_LSB)
                  | (32'(PORT_IND) << SP_PIND_BIT)
                  | (32'(DEBUG_PORT) << SP_DPN_LSB);
  assign cappar_o = (32'(WIDE_ADDR) << CP_WIDE_ADDRESS_CAPABLE_BIT)
                  | (32'(FLIST_PROG) << CP_FRAME_LIST_PROGRAMMABLE_BIT)
                  | (32'(PARK_CAP) << CP_PARK_CAPABLE_BIT)
                  | (32'(ISO_THRESH) << CP_IST_LSB)
                  | (32'(EXT_CAP_PTR) << CP_EXTENDED_CAP_POINTER_LSB);
  assign route_o  = {4'h0, ROUTE_RESET};
endmodule : uhc_cap_rom
`default_nettype wire

// file: rtl/uhc_regs.sv
// Host controller capability bank and command register
//
// Overview of operation
// - Reads of undefined addresses may return anything; this block returns zero.
// - Write-only bits always read back as zero.
// - Write-one-to-clear bits clear on a one and ignore a zero.
// - Upper half of first word holds the read-only BCD interface version.
// - Low byte of first word reads capability length 0x10.
// - Structural word low nibble reports two downstream ports.
// - Port count must lie between one and fifteen.
// - Bits 15..12 report one full-speed companion controller.
// - Bits 11..8 report two ports per companion.
// - Routing rule bit reads zero: ascending assignment to companions.
// - Port power switchable bit reads one.
// - Debug port field reads zero, no debug port.
// - Port indicator support bit reads zero.
// - Extended capability pointer reads 0xa0.
// - Isochronous threshold field reads 0001.
// - Park capable bit reads one; park fields of command are writable.
// - Frame list programmable bit reads one; size field writable.
// - Wide address bit reads zero: 32-bit structures only.
// - Sixty-bit companion route map, read-only, resets to zero.
// - Capability words at base plus offset; operational area sixteen above.
`timescale 1ns/1ns
`default_nettype none
module uhc_regs
  import uhc_pkg::*;
#(
  parameter logic [15:0] IFACE_VERSION = 16'h0abc, // Arbitrary value, set per product
  parameter logic [3:0]  N_PORTS       = 4'h2      // Downstream port count
) (
  input  wire logic                      clk_i,        // Bus clock
  input  wire logic                      rst_n_i,      // Async reset, active low
  input  wire logic                      req_i,        // Access strobe
  input  wire logic                      we_i,         // 1 write, 0 read
  input  wire logic [uhc_pkg::ADDR_W-1:0] addr_i,      // Byte offset from base
  input  wire logic [31:0]               wdata_i,      // Write data
  input  wire logic                      reset_done_i, // Controller finished reset
  output logic                           ack_o,        // Access done pulse
  output logic [31:0]                    rdata_o,      // Read data
  output logic [31:0]                    host_command_o // Command register value
);
  import uhc_pkg::*;

  // Port count outside 1..15 cannot be reported
  if (N_PORTS == 4'h0) begin : g_bad_ports
    $error("N_PORTS must be 1 to 15");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Constant words
  logic [31:0] cap0_w;
  logic [31:0] struct_w;
  logic [31:0] cappar_w;
  logic [63:0] route_w;

  uhc_cap_rom #(
    .IFACE_VERSION (IFACE_VERSION),
    .N_PORTS       (N_PORTS)
  ) u_rom (
    .cap0_o   (cap0_w),
    .struct_o (struct_w),
    .cappar_o (cappar_w),
    .route_o  (route_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, full words only
  logic hit_cap0;
  logic hit_struct;
  logic hit_cappar;
  logic hit_route;
  logic hit_cmd;
  logic cmd_wr;

  assign hit_cap0   = (addr_i == OFS_CAPLEN_VER);
  assign hit_struct = (addr_i == OFS_STRUCT);
  assign hit_cappar = (addr_i == OFS_CAPPAR);
  assign hit_route  = (addr_i == OFS_ROUTE_LO);
  assign hit_cmd    = (addr_i == OFS_HOST_CMD);
  // Writes elsewhere are dropped so read-only words never move
  assign cmd_wr     = req_i & we_i & hit_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Command register next value
  logic [31:0] cmd_q;
  logic [31:0] cmd_d;
  logic [31:0] cmd_wval;

  // Writable bits only; park and size fields writable as capabilities say
  assign cmd_wval = wdata_i & CMD_RW_MASK;
  // Self-clearing reset bits drop when the controller signals completion;
  // software cannot clear a reset bit in progress, a written zero is ignored.
  // Completion in the same cycle as a write of zero to the bit still clears it;
  // a written one wins over completion
  always_comb begin
    cmd_d = cmd_wr ? cmd_wval : cmd_q;
    cmd_d[CMD_HCR_BIT]  = (cmd_wr & wdata_i[CMD_HCR_BIT]) | (cmd_q[CMD_HCR_BIT] & ~reset_done_i);
    cmd_d[CMD_LIGHT_CONTROLLER_RESET_BIT] = (cmd_wr & wdata_i[CMD_LIGHT_CONTROLLER_RESET_BIT]) | (cmd_q[CMD_LIGHT_CONTROLLER_RESET_BIT] & ~reset_done_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets return zero, reserved bits are zero
  logic [31:0] rd_w;
  assign rd_w = hit_cap0   ? cap0_w :
                hit_struct ? struct_w :
                hit_cappar ? cappar_w :
                hit_route  ? route_w[31:0] :
                hit_cmd    ? cmd_q : 32'h0000_0000;

  // One-cycle answer, registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      ack_o   <= req_i;
      rdata_o <= (req_i && !we_i) ? rd_w : 32'h0000_0000;
    end
  end

  // Route high word shares offset with the command register; it is
  // all zero so its bits are not lost
  assign host_command_o = cmd_q;
endmodule : uhc_regs
`default_nettype wire

// file: tb/uhc_regs_monitor.sv
// Concurrent checks on the capability bank ports
`timescale 1ns/1ns
`default_nettype none
module uhc_regs_monitor
  import uhc_pkg::*;
#(
  parameter logic [15:0] IFACE_VERSION = 16'h0abc // Arbitrary value
) (
  input wire logic               clk_i,         // Bus clock
  input wire logic               rst_n_i,       // Async reset, active low
  input wire logic               req_i,         // Access strobe
  input wire logic               we_i,          // Write select
  input wire logic [ADDR_W-1:0]  addr_i,        // Byte offset
  input wire logic [31:0]        wdata_i,       // Write data
  input wire logic               reset_done_i,  // Reset finished
  input wire logic               ack_o,         // Access done
  input wire logic [31:0]        rdata_o,       // Read data
  input wire logic [31:0]        host_command_o // Command value
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Reads and writes taken at one edge, answered at the next
  sequence s_rd(logic [11:0] a); req_i && !we_i && addr_i == a; endsequence
  sequence s_wr(logic hit); req_i && we_i && !reset_done_i && hit; endsequence
  AST_ACK_AFTER_REQ: assert property (req_i |=> ack_o)
    else $error("no ack after request");
  AST_NO_SPURIOUS_ACK: assert property (!req_i |=> !ack_o)
    else $error("ack without request");
  AST_CAP0_WORD: assert property (s_rd(OFS_CAPLEN_VER) |=> rdata_o == {IFACE_VERSION, 8'h00, 8'h10})
    else $error("bad first capability word");
  AST_STRUCT_WORD: assert property (s_rd(OFS_STRUCT) |=> rdata_o == 32'h0000_1212)
    else $error("bad structural word");
  AST_CAPPAR_WORD: assert property (s_rd(OFS_CAPPAR) |=> rdata_o == 32'h0000_a016)
    else $error("bad capability parameter word");
  AST_ROUTE_WORD: assert property (s_rd(OFS_ROUTE_LO) |=> rdata_o == 32'h0)
    else $error("route map not zero");
  AST_RO_WRITE: assert property (s_wr(addr_i != OFS_HOST_CMD) |=> $stable(host_command_o))
    else $error("write elsewhere changed command");
  // Threshold, park and frame list size fields follow the write; reserved bit 10 stays zero
  property p_cmd_fields;
    s_wr(addr_i == OFS_HOST_CMD) |=> host_command_o[23:16] == $past(wdata_i[23:16])
      && host_command_o[11] == $past(wdata_i[11]) && host_command_o[10] == 1'b0
      && host_command_o[9:8] == $past(wdata_i[9:8]) && host_command_o[3:2] == $past(wdata_i[3:2]);
  endproperty
  AST_CMD_WRITE: assert property (p_cmd_fields)
    else $error("command fields not written");
endmodule : uhc_regs_monitor
`default_nettype wire

// file: tb/uhc_cpu_model.sv
// CPU side bus master model, full words only
`timescale 1ns/1ns
`default_nettype none
module uhc_cpu_model (
  input  wire logic        clk_i,   // Bus clock
  input  wire logic        ack_i,   // Access done
  input  wire logic [31:0] rdata_i, // Read data
  output logic             req_o,   // Access strobe
  output logic             we_o,    // Write select
  output logic [11:0]      addr_o,  // Byte offset
  output logic [31:0]      wdata_o  // Write data
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 12'h000;
    wdata_o = 32'h0;
  end
  // One word per access, at the falling edge; idle lines inverted so stale values never pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(negedge clk_i);
    {req_o, we_o, addr_o, wdata_o} = {1'b1, w, a, d};
    @(negedge clk_i);
    r = ack_i ? rdata_i : 32'hx;
    {req_o, we_o, addr_o, wdata_o} = {1'b0, ~w, ~a, ~d};
  endtask : xfer
endmodule : uhc_cpu_model
`default_nettype wire

// file: tb/usb_host_capability_regs_tb.sv
// Self-checking bench for the capability bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module usb_host_capability_regs_tb;
  import uhc_pkg::*;
  localparam logic [15:0] VER = 16'h0abc; // Arbitrary value
  logic        clk_i = 1'b0, rst_n_i = 1'b0, reset_done_i = 1'b0, req_i, we_i, ack_o;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o, host_command_o, rd;
  int          n_mismatch = 0, tests_run = 0;
  initial forever #10 clk_i = ~clk_i;
  uhc_regs #(.IFACE_VERSION(VER), .N_PORTS(4'h2)) uhc_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .reset_done_i(reset_done_i), .ack_o(ack_o), .rdata_o(rdata_o),
    .host_command_o(host_command_o));
  uhc_cpu_model uhc_cpu_model_inst (.clk_i(clk_i), .ack_i(ack_o), .rdata_i(rdata_o), .req_o(req_i), .we_o(we_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_caps();
    logic [11:0] a[4] = '{12'h000, 12'h004, 12'h008, 12'h00c};
    logic [31:0] e[4] = '{{VER, 8'h00, 8'h10}, 32'h0000_1212, 32'h0000_a016, 32'h0};
    `CHK(host_command_o, 32'h0008_0b00)
    foreach (a[i]) begin
      uhc_cpu_model_inst.xfer(1'b0, a[i], 32'h0, rd);
      `CHK(rd, e[i])
    end
    $display("t_caps done");
  endtask : t_caps
  // Writes to read-only words must leave everything alone; unmapped places are only read
  task automatic t_ro();
    logic [11:0] a[4] = '{12'h000, 12'h004, 12'h008, 12'h00c};
    foreach (a[i])
      uhc_cpu_model_inst.xfer(1'b1, a[i], 32'hffff_ffff, rd);
    `CHK(host_command_o, 32'h0008_0b00)
    uhc_cpu_model_inst.xfer(1'b0, 12'h004, 32'h0, rd);
    `CHK(rd, 32'h0000_1212)
    uhc_cpu_model_inst.xfer(1'b0, 12'h100, 32'h0, rd);
    `CHK(rd, 32'h0)
    $display("t_ro done");
  endtask : t_ro
  // All ones, read back, reset completion, all zeros; then a zero must not clear set reset bits
  task automatic t_cmd();
    uhc_cpu_model_inst.xfer(1'b1, 12'h010, 32'hffff_ffff, rd);
    `CHK(host_command_o, 32'h00ff_0bff)
    uhc_cpu_model_inst.xfer(1'b0, 12'h010, 32'h0, rd);
    `CHK(rd, 32'h00ff_0bff)
    @(negedge clk_i) reset_done_i = 1'b1;
    @(negedge clk_i) reset_done_i = 1'b0;
    `CHK(host_command_o, 32'h00ff_0b7d)
    uhc_cpu_model_inst.xfer(1'b1, 12'h010, 32'h0, rd);
    `CHK(host_command_o, 32'h0)
    uhc_cpu_model_inst.xfer(1'b1, 12'h010, 32'h0000_0082, rd);
    uhc_cpu_model_inst.xfer(1'b1, 12'h010, 32'h0, rd);
    `CHK(host_command_o, 32'h0000_0082)
    @(negedge clk_i) reset_done_i = 1'b1;
    @(negedge clk_i) reset_done_i = 1'b0;
    `CHK(host_command_o, 32'h0)
    $display("t_cmd done");
  endtask : t_cmd
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_caps();
    t_ro();
    t_cmd();
    report_and_stop();
  end
  // Whole run needs well under 100 cycles
  initial begin
    #(20 * 500);
    n_mismatch++;
    report_and_stop();
  end
endmodule : usb_host_capability_regs_tb
bind uhc_regs uhc_regs_monitor #(.IFACE_VERSION(IFACE_VERSION)) uhc_regs_monitor_inst (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .reset_done_i(reset_done_i),
  .ack_o(ack_o), .rdata_o(rdata_o), .host_command_o(host_command_o));
`default_nettype wire
